// [design/cmpc_pkg.sv]
/*
  package for the comparator control block: register offset, field
  positions, reset value, hysteresis codes and the carrier structs.
  assumes an 8-bit special-register port driven by the processor core.
*/
// Function
// (R1) enable bit switches comparator on and off
// (R2) rising output edge sets rise flag
// (R3) falling output edge sets fall flag
// (R4) flags stay set until software clears
// (R5) output-state bit reads live result, read-only
// (R6) each edge flag raises an interrupt request
// (R7) enabled with low output wakes oscillator
// (R8) low nibble holds both hysteresis selectors
// (R9) positive codes: off, 5, 10, 20 mV
// (R10) negative codes: off, 5, 10, 20 mV
// (R11) spurious edges after mode change are kept
// (R12) software clears flags after power-up time
// (R13) disabled comparator drives pin output low
// (R14) two-flop sync then compare for edges
package cmpc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CMPC_CTRL_ADDR = 8'h9b;
  localparam logic [7:0] CMPC_CTRL_RESET = 8'h00;
  localparam int CMPC_BIT_EN = 7;
  localparam int CMPC_BIT_OUT = 6;
  localparam int CMPC_BIT_RISE = 5;
  localparam int CMPC_BIT_FALL = 4;
  localparam int CMPC_HYP_LSB = 2;
  localparam int CMPC_HYN_LSB = 0;

  // ****************************************************************
  // hysteresis codes, amount in mV
  // ****************************************************************
  typedef enum logic [1:0] {
    CMPC_HYST_OFF = 2'h0,
    CMPC_HYST_5MV = 2'h1,
    CMPC_HYST_10MV = 2'h2,
    CMPC_HYST_20MV = 2'h3
  } cmpc_hyst_t;

  localparam logic [4:0] CMPC_MV_OFF = 5'h00;
  localparam logic [4:0] CMPC_MV_5 = 5'h05;
  localparam logic [4:0] CMPC_MV_10 = 5'h0a;
  localparam logic [4:0] CMPC_MV_20 = 5'h14;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmpc_bus_t;

  typedef struct packed {
    logic enable;
    logic [4:0] pos_mv;
    logic [4:0] neg_mv;
    logic [1:0] pos_sel;
    logic [1:0] neg_sel;
  } cmpc_analog_ctl_t;

  function automatic logic [4:0] cmpc_hyst_mv(input logic [1:0] code);
    unique case (cmpc_hyst_t'(code))
      CMPC_HYST_OFF: cmpc_hyst_mv = CMPC_MV_OFF;
      CMPC_HYST_5MV: cmpc_hyst_mv = CMPC_MV_5;
      CMPC_HYST_10MV: cmpc_hyst_mv = CMPC_MV_10;
      CMPC_HYST_20MV: cmpc_hyst_mv = CMPC_MV_20;
    endcase
  endfunction

endpackage

// [design/cmpc_sync.sv]
/*
  two-flop synchroniser for the raw comparator result.
  assumes the input is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module cmpc_sync (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic async_in,
  output logic sync_out
);
  import cmpc_pkg::*;

  typedef struct packed {
    logic meta;
    logic stable;
  } cmpc_sync_state_t;

  cmpc_sync_state_t state;
  cmpc_sync_state_t next_state;

  always_comb begin
    next_state.meta = async_in; // R14
    next_state.stable = state.meta; // R14
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;

endmodule // cmpc_sync

// [design/cmpc_top.sv]
/*
  comparator control and status: control register, edge flags,
  interrupt requests, wake request and the latched pin output.
  assumes a single-cycle register write strobe and a combinational
  read decode by the core; the raw result comes from the analog core.
*/
`timescale 1ns/1ps
module cmpc_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire cmpc_pkg::cmpc_bus_t reg_bus,
  output logic [7:0] reg_rdata,
  input wire logic cmp_raw,
  output cmpc_pkg::cmpc_analog_ctl_t analog_ctl,
  output logic irq_rise,
  output logic irq_fall,
  output logic wake_req,
  output logic cmp_pin_out
);
  import cmpc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic cmp_enable;
    logic cmp_rise_flag;
    logic cmp_fall_flag;
    logic [1:0] cmp_pos_hyst_sel;
    logic [1:0] cmp_neg_hyst_sel;
    logic prev;
    logic [7:0] rdata;
    cmpc_analog_ctl_t actl;
    logic irq_rise;
    logic irq_fall;
    logic wake;
    logic pin;
  } cmpc_state_t;

  cmpc_state_t state;
  cmpc_state_t next_state;
  logic cmp_output_state;
  logic rise_edge;
  logic fall_edge;
  logic wr_ctrl;

  cmpc_sync u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(cmp_raw),
    .sync_out(cmp_output_state)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    wr_ctrl = reg_bus.wr && (reg_bus.addr == CMPC_CTRL_ADDR);
    // edges only counted while on; spurious power-up edges pass through
    rise_edge = state.cmp_enable && cmp_output_state && !state.prev; // R14 R2 R11
    fall_edge = state.cmp_enable && !cmp_output_state && state.prev; // R14 R3 R11
    next_state.prev = cmp_output_state; // R14
    if (wr_ctrl) begin
      next_state.cmp_enable = reg_bus.wdata[CMPC_BIT_EN]; // R1
      next_state.cmp_rise_flag = reg_bus.wdata[CMPC_BIT_RISE]; // R4 R12
      next_state.cmp_fall_flag = reg_bus.wdata[CMPC_BIT_FALL]; // R4 R12
      next_state.cmp_pos_hyst_sel = reg_bus.wdata[CMPC_HYP_LSB +: 2]; // R8
      next_state.cmp_neg_hyst_sel = reg_bus.wdata[CMPC_HYN_LSB +: 2]; // R8
    end
    // set wins over a clearing write in the same cycle
    if (rise_edge) begin
      next_state.cmp_rise_flag = 1'b1; // R2 R4
    end
    if (fall_edge) begin
      next_state.cmp_fall_flag = 1'b1; // R3 R4
    end
    next_state.rdata = '0;
    next_state.rdata[CMPC_BIT_EN] = next_state.cmp_enable;
    next_state.rdata[CMPC_BIT_OUT] = state.cmp_enable && cmp_output_state; // R5
    next_state.rdata[CMPC_BIT_RISE] = next_state.cmp_rise_flag;
    next_state.rdata[CMPC_BIT_FALL] = next_state.cmp_fall_flag;
    next_state.rdata[CMPC_HYP_LSB +: 2] = next_state.cmp_pos_hyst_sel;
    next_state.rdata[CMPC_HYN_LSB +: 2] = next_state.cmp_neg_hyst_sel;
    next_state.actl.enable = next_state.cmp_enable; // R1
    next_state.actl.pos_sel = next_state.cmp_pos_hyst_sel; // R8
    next_state.actl.neg_sel = next_state.cmp_neg_hyst_sel; // R8
    next_state.actl.pos_mv = cmpc_hyst_mv(next_state.cmp_pos_hyst_sel); // R9
    next_state.actl.neg_mv = cmpc_hyst_mv(next_state.cmp_neg_hyst_sel); // R10
    next_state.irq_rise = next_state.cmp_rise_flag; // R6
    next_state.irq_fall = next_state.cmp_fall_flag; // R6
    next_state.wake = state.cmp_enable && !cmp_output_state; // R7
    next_state.pin = state.cmp_enable && cmp_output_state; // R13
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // outputs, all registered
  // ****************************************************************
  assign reg_rdata = state.rdata;
  assign analog_ctl = state.actl;
  assign irq_rise = state.irq_rise;
  assign irq_fall = state.irq_fall;
  assign wake_req = state.wake;
  assign cmp_pin_out = state.pin;

endmodule // cmpc_top

// [test/cmpc_top_sva.sv]
/*
  checker for cmpc_top: register writes, edge flags, wake and pin output.
  assumes it sees only the top ports, bound at the foot of this file.
*/
`timescale 1ns/1ps
module cmpc_top_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire cmpc_pkg::cmpc_bus_t reg_bus,
  input wire logic [7:0] reg_rdata,
  input wire logic cmp_raw,
  input wire cmpc_pkg::cmpc_analog_ctl_t analog_ctl,
  input wire logic irq_rise,
  input wire logic irq_fall,
  input wire logic wake_req,
  input wire logic cmp_pin_out
);
  import cmpc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic hit;
  assign hit = reg_bus.wr && reg_bus.addr == CMPC_CTRL_ADDR;
  function automatic logic [4:0] mv(input logic [1:0] c);
    return c == 2'h0 ? 5'h00 : c == 2'h1 ? 5'h05 : c == 2'h2 ? 5'h0a : 5'h14;
  endfunction
  // ****************************************************************
  // edge sequences: raw held for the whole sync delay
  // ****************************************************************
  sequence rise_held;
    reg_rdata[7] && $rose(cmp_raw) ##1 (cmp_raw && reg_rdata[7])[*3];
  endsequence
  sequence fall_held;
    reg_rdata[7] && $fell(cmp_raw) ##1 (!cmp_raw && reg_rdata[7])[*3];
  endsequence
  ctrl_write_a: assert property (hit |=> reg_rdata[7] == $past(reg_bus.wdata[7]) &&
    analog_ctl.enable == $past(reg_bus.wdata[7]) && reg_rdata[3:0] == $past(reg_bus.wdata[3:0]))
    else $error("control write not taken");
  hyst_decode_a: assert property (analog_ctl.pos_mv == mv(analog_ctl.pos_sel) &&
    analog_ctl.neg_mv == mv(analog_ctl.neg_sel)) else $error("hysteresis decode wrong");
  flag_sticky_a: assert property (reg_rdata[5] && reg_rdata[4] && !hit |=> reg_rdata[5] && reg_rdata[4])
    else $error("edge flag dropped");
  rise_flag_a: assert property (rise_held |-> ##[0:2] irq_rise) else $error("rise not flagged");
  fall_flag_a: assert property (fall_held |-> ##[0:2] irq_fall) else $error("fall not flagged");
  irq_level_a: assert property (irq_rise == reg_rdata[5] && irq_fall == reg_rdata[4])
    else $error("irq differs from flag");
  wake_low_a: assert property ((reg_rdata[7] && !cmp_raw)[*5] |-> wake_req) else $error("no wake");
  out_state_a: assert property ((reg_rdata[7] && cmp_raw)[*5] |-> reg_rdata[6]) else $error("state bit low");
  pin_off_a: assert property ((!reg_rdata[7])[*2] |-> !cmp_pin_out && !reg_rdata[6])
    else $error("pin high while off");
endmodule // cmpc_top_sva
bind cmpc_top cmpc_top_sva u_sva (.sys_clk(sys_clk), .nrst(nrst), .reg_bus(reg_bus), .reg_rdata(reg_rdata),
  .cmp_raw(cmp_raw), .analog_ctl(analog_ctl), .irq_rise(irq_rise), .irq_fall(irq_fall), .wake_req(wake_req),
  .cmp_pin_out(cmp_pin_out));

// [test/comparator_control_edge_flags_tb_top.sv]
/*
  testbench for cmpc_top: register writes, edges, wake and disable.
  assumes the fixed three-edge flag latency of the design.
*/
`timescale 1ns/1ps
module comparator_control_edge_flags_tb_top;
  import cmpc_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  cmpc_bus_t reg_bus = '0;
  logic cmp_raw = 1'b0;
  logic [7:0] reg_rdata;
  cmpc_analog_ctl_t analog_ctl;
  logic irq_rise, irq_fall, wake_req, cmp_pin_out;
  logic [4:0] mv [4] = '{5'h00, 5'h05, 5'h0a, 5'h14};
  int n_fail = 0;
  int samples_checked = 0;
  always #2 sys_clk = ~sys_clk;
  cmpc_top DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_bus(reg_bus), .reg_rdata(reg_rdata), .cmp_raw(cmp_raw),
    .analog_ctl(analog_ctl), .irq_rise(irq_rise), .irq_fall(irq_fall), .wake_req(wake_req), .cmp_pin_out(cmp_pin_out));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_bus = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_bus.wr = 1'b0;
    @(negedge sys_clk);
  endtask
  // raw held long enough to pass the two sync flops
  task automatic set_raw(input logic v);
    cmp_raw = v;
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic close_out();
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    chk("ctrl_reset", reg_rdata, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h9b, 8'h80 | 8'(c * 5));
      chk("hyst_bits", reg_rdata, 8'h80 | 8'(c * 5));
      chk("hyst_sel", {4'h0, analog_ctl.pos_sel, analog_ctl.neg_sel}, 8'(c * 5));
      chk("enable_on", {7'h00, analog_ctl.enable}, 8'h01);
      chk("pos_mv", {3'h0, analog_ctl.pos_mv}, {3'h0, mv[c]});
      chk("neg_mv", {3'h0, analog_ctl.neg_mv}, {3'h0, mv[c]});
    end
    set_raw(1'b0);
    chk("wake_low", {7'h00, wake_req}, 8'h01);
    set_raw(1'b1);
    chk("rise", reg_rdata, 8'hef);
    chk("irq_rise", {6'h00, irq_rise, irq_fall}, 8'h02);
    chk("wake_high", {7'h00, wake_req}, 8'h00);
    chk("pin_on", {7'h00, cmp_pin_out}, 8'h01);
    set_raw(1'b0);
    chk("fall", reg_rdata, 8'hbf);
    chk("irq_both", {6'h00, irq_rise, irq_fall}, 8'h03);
    chk("pin_low", {7'h00, cmp_pin_out}, 8'h00);
    wr(8'h9b, 8'hc3);
    chk("clear", reg_rdata, 8'h83);
    wr(8'h9c, 8'h00);
    chk("unmapped", reg_rdata, 8'h83);
    // synced edge lands on the same edge as the clearing write
    cmp_raw = 1'b1;
    @(negedge sys_clk);
    wr(8'h9b, 8'h83);
    chk("set_wins", reg_rdata, 8'he3);
    wr(8'h9b, 8'h00);
    set_raw(1'b0);
    chk("wake_off", {7'h00, wake_req}, 8'h00);
    set_raw(1'b1);
    chk("disabled", reg_rdata, 8'h00);
    chk("enable_off", {7'h00, analog_ctl.enable}, 8'h00);
    chk("pin_off", {7'h00, cmp_pin_out}, 8'h00);
    close_out();
  end
endmodule // comparator_control_edge_flags_tb_top
